/* File: design/acs_defines.vh */
// shared constants of the calibration-mode sequencer
// assumes inclusion by bare name from every design file
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH
// register byte offsets
`define ACS_OFF_CTRL 8'h00
`define ACS_OFF_STAT 8'h04
`define ACS_OFF_MASK 8'h08
`define ACS_OFF_INT 8'h0c
`define ACS_OFF_DATA 8'h10
`define ACS_OFF_ZCOEF 8'h14
`define ACS_OFF_FCOEF 8'h18
// control fields
`define ACS_CH_LSB 0
`define ACS_MD_LSB 4
// mode codes
`define ACS_MD_NORMAL 3'h0
`define ACS_MD_SYSOFS 3'h4
`define ACS_MD_BKGND 3'h5
`define ACS_MD_ZSSELF 3'h6
// interrupt status bits
`define ACS_IRQ_CALDONE 0
`define ACS_IRQ_CONV 1
`define ACS_IRQ_BKCAL 2
// reset values
`define ACS_CTRL_RST 8'h00
`define ACS_MASK_RST 3'h0
// timing in cycles; background ratio in words
`define ACS_CONV_CYC 16'd64
`define ACS_CAL_CYC 16'd64
`define ACS_BK_RATIO 3'd6
`endif

/* File: design/acs_sync2.v */
// two-flop synchroniser for one pin level
// assumes an asynchronous active-low reset on hclk
`timescale 1ns/1ns
`include "acs_defines.vh"
module acs_sync2 (
  input wire hclk,
  input wire hresetn,
  input wire d,
  output reg q
);
  reg meta_reg;
  // first flop feeds only the second
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

/* File: design/acs_timer.v */
// down-counting phase timer, pulse on expiry
// assumes a start pulse loads the count, abort stops it
`timescale 1ns/1ns
`include "acs_defines.vh"
module acs_timer (
  input wire hclk,
  input wire hresetn,
  input wire start,
  input wire abort,
  input wire [15:0] length,
  output reg done
);
  reg [15:0] cnt_reg;
  reg run_reg;
  // count down while running
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 16'h0000;
      run_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        run_reg <= 1'b0;
      end else if (start) begin
        cnt_reg <= (length == 16'h0000) ? 16'h0000 : length - 16'h0001;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (cnt_reg == 16'h0000) begin
          run_reg <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 16'h0001;
        end
      end
    end
  end
endmodule

/* File: design/acs_top.v */
// calibration-mode sequencer of a sigma-delta converter, AHB-Lite slave
// assumes one hclk domain; the analog front end is modelled by handshake pins
//
// Overview of operation
// - mode code 1,0,0 runs a system offset calibration on the selected channel at its gain.
// - offset and zero-scale self-calibration are one step and then clear the mode to 0,0,0.
// - data_ready_n goes high as a one-step calibration starts and low after a new word.
// - in system offset mode the full-scale point uses the internal reference over gain.
// - mode code 1,0,1 self-calibrates within conversions, one zero-scale step after every sixth word.
// - background mode interleaves zero-scale calibrations and updates coefficients itself.
// - mode code 1,1,0 runs a zero-scale self-calibration on shorted inputs.
`timescale 1ns/1ns
`include "acs_defines.vh"
module acs_top (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [23:0] conv_word,
  input wire inputs_stable,
  output reg data_ready_n,
  output reg short_inputs,
  output reg fs_internal_ref,
  output reg zs_coef_update,
  output reg irq
);
  // ************************************************
  // state encoding
  // ************************************************
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_CONV = 5'b00010;
  localparam [4:0] ST_ZCAL = 5'b00100;
  localparam [4:0] ST_FCAL = 5'b01000;
  localparam [4:0] ST_WORD = 5'b10000;

  // sequencer and register state
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [7:0] ctrl_reg;
  reg [2:0] mask_reg;
  reg [2:0] stat_reg;
  reg [23:0] data_reg;
  reg [23:0] zs_coef_reg;
  reg [23:0] fs_coef_reg;
  reg [2:0] cal_chan_reg;
  reg [2:0] bk_cnt_reg;
  reg one_step_reg;
  // captured address phase
  reg ap_valid_reg;
  reg ap_write_reg;
  reg [7:0] ap_addr_reg;
  // sequencer strobes and helper links
  reg [2:0] ev_set;
  reg tmr_start;
  reg [15:0] tmr_len;
  wire tmr_done;
  wire stable_sync;
  // decoded control fields and bus strobes
  wire [2:0] mode = ctrl_reg[`ACS_MD_LSB+2:`ACS_MD_LSB];
  wire [2:0] chan = ctrl_reg[`ACS_CH_LSB+2:`ACS_CH_LSB];
  wire bus_wr = ap_valid_reg & ap_write_reg;
  wire ctrl_wr = bus_wr & (ap_addr_reg == `ACS_OFF_CTRL);
  wire stat_rd = ap_valid_reg & ~ap_write_reg & (ap_addr_reg == `ACS_OFF_STAT);
  // status after the read clear and new events; set wins
  wire [2:0] stat_after = (stat_reg & ~{3{stat_rd}}) | ev_set;

  // ************************************************
  // helpers
  // ************************************************
  // stable-input pin from the outside world
  acs_sync2 u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(inputs_stable),
    .q(stable_sync)
  );

  // phase timer for conversions and calibrations
  acs_timer u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(tmr_start),
    .abort(ctrl_wr),
    .length(tmr_len),
    .done(tmr_done)
  );

  // ************************************************
  // bus slave
  // ************************************************
  // latch address phase, zero wait states
  // hsize not decoded: every register is one whole word
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        ap_valid_reg <= hsel & htrans[1];
        ap_write_reg <= hwrite;
        ap_addr_reg <= haddr;
      end
    end
  end

  function [7:0] ctrl_next_view;
    input [7:0] c;
    begin
      ctrl_next_view = c;
    end
  endfunction

  // read data registered in the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hready & hsel & htrans[1] & ~hwrite) begin
      case (haddr)
        `ACS_OFF_CTRL: hrdata <= {24'h000000, ctrl_next_view(ctrl_reg)};
        `ACS_OFF_STAT: hrdata <= {29'h00000000, stat_reg | ev_set};
        `ACS_OFF_MASK: hrdata <= {29'h00000000, mask_reg};
        `ACS_OFF_INT: hrdata <= {24'h000000, state_reg, 2'b00, ~data_ready_n};
        `ACS_OFF_DATA: hrdata <= {8'h00, data_reg};
        `ACS_OFF_ZCOEF: hrdata <= {5'h00, cal_chan_reg, zs_coef_reg};
        `ACS_OFF_FCOEF: hrdata <= {8'h00, fs_coef_reg};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // ************************************************
  // sequencer
  // ************************************************
  // next state and timer launches
  always @* begin
    state_next = state_reg;
    tmr_start = 1'b0;
    tmr_len = `ACS_CONV_CYC;
    ev_set = 3'b000;
    case (state_reg)
      ST_IDLE: begin
        if (mode == `ACS_MD_SYSOFS) begin
          // offset point waits for the steady input
          if (stable_sync) begin
            state_next = ST_ZCAL;
            tmr_start = 1'b1;
            tmr_len = `ACS_CAL_CYC;
          end
        end else if (mode == `ACS_MD_ZSSELF) begin
          state_next = ST_ZCAL;
          tmr_start = 1'b1;
          tmr_len = `ACS_CAL_CYC;
        end else begin
          state_next = ST_CONV;
          tmr_start = 1'b1;
        end
      end
      ST_CONV: begin
        // word lands when the conversion phase ends
        if (tmr_done) begin
          state_next = ST_WORD;
        end
      end
      ST_ZCAL: begin
        if (tmr_done) begin
          if (one_step_reg && mode == `ACS_MD_SYSOFS) begin
            state_next = ST_FCAL;
            tmr_start = 1'b1;
            tmr_len = `ACS_CAL_CYC;
          end else begin
            state_next = ST_CONV;
            tmr_start = 1'b1;
            if (!one_step_reg) begin
              ev_set[`ACS_IRQ_BKCAL] = 1'b1;
            end
          end
        end
      end
      ST_FCAL: begin
        // full-scale step, then one conversion
        if (tmr_done) begin
          state_next = ST_CONV;
          tmr_start = 1'b1;
        end
      end
      ST_WORD: begin
        ev_set[`ACS_IRQ_CONV] = 1'b1;
        if (one_step_reg) begin
          ev_set[`ACS_IRQ_CALDONE] = 1'b1;
        end
        // one in seven slots, the one after every sixth word, goes to a zero-scale calibration
        if (mode == `ACS_MD_BKGND && bk_cnt_reg == `ACS_BK_RATIO - 3'd1) begin
          state_next = ST_ZCAL;
          tmr_start = 1'b1;
          tmr_len = `ACS_CAL_CYC;
        end else begin
          state_next = ST_CONV;
          tmr_start = 1'b1;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // a new mode restarts the sequence
    if (ctrl_wr) begin
      state_next = ST_IDLE;
      tmr_start = 1'b0;
    end
  end

  // state, control and data registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
      ctrl_reg <= `ACS_CTRL_RST;
      mask_reg <= `ACS_MASK_RST;
      one_step_reg <= 1'b0;
      bk_cnt_reg <= 3'd0;
      data_reg <= 24'h000000;
      zs_coef_reg <= 24'h000000;
      fs_coef_reg <= 24'h000000;
      cal_chan_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      if (ctrl_wr) begin
        ctrl_reg <= {1'b0, hwdata[6:0]};
      end else if (state_reg == ST_WORD && one_step_reg) begin
        ctrl_reg[`ACS_MD_LSB+2:`ACS_MD_LSB] <= `ACS_MD_NORMAL;
      end
      if (bus_wr && ap_addr_reg == `ACS_OFF_MASK) begin
        mask_reg <= hwdata[2:0];
      end
      // one-step flag set on launch, cleared once the word lands
      if (ctrl_wr) begin
        one_step_reg <= 1'b0;
      end else if (state_reg == ST_IDLE && state_next == ST_ZCAL) begin
        one_step_reg <= 1'b1;
      end else if (state_reg == ST_WORD) begin
        one_step_reg <= 1'b0;
      end
      if (ctrl_wr) begin
        bk_cnt_reg <= 3'd0;
      end else if (state_reg == ST_WORD) begin
        bk_cnt_reg <= (bk_cnt_reg == `ACS_BK_RATIO - 3'd1) ? 3'd0 : bk_cnt_reg + 3'd1;
      end
      if (state_reg == ST_CONV && tmr_done) begin
        data_reg <= conv_word;
      end
      if (state_reg == ST_ZCAL && tmr_done) begin
        zs_coef_reg <= conv_word;
        cal_chan_reg <= chan;
      end
      // full-scale point against the internal reference
      if (state_reg == ST_FCAL && tmr_done) begin
        fs_coef_reg <= conv_word;
      end
    end
  end

  // ************************************************
  // outputs and interrupts
  // ************************************************
  // front-end steering and ready pin
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_ready_n <= 1'b1;
      short_inputs <= 1'b0;
      fs_internal_ref <= 1'b0;
      zs_coef_update <= 1'b0;
    end else begin
      short_inputs <= (state_next == ST_ZCAL) && (mode != `ACS_MD_SYSOFS);
      fs_internal_ref <= (state_next == ST_FCAL);
      zs_coef_update <= (state_reg == ST_ZCAL) && tmr_done;
      if (ctrl_wr || (state_reg == ST_IDLE && state_next == ST_ZCAL)) begin
        data_ready_n <= 1'b1;
      end else if (state_reg == ST_WORD) begin
        data_ready_n <= 1'b0;
      end
    end
  end

  // ************************************************
  // interrupts
  // ************************************************
  // sticky status bits and the level interrupt
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_reg <= 3'b000;
      irq <= 1'b0;
    end else begin
      stat_reg <= stat_after;
      irq <= |(stat_after & mask_reg);
    end
  end
endmodule

/* File: tb/acs_props.sv */
// port checker of the calibration sequencer
// assumes binding to acs_top in one hclk domain
`timescale 1ns/1ns
module acs_props (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire data_ready_n,
  input wire short_inputs,
  input wire fs_internal_ref,
  input wire zs_coef_update
);
  // ****
  // properties
  // ****
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // control write: address phase, then data phase
  sequence ctrl_wr_s;
    hsel && hready && htrans[1] && hwrite && haddr == 8'h00 ##1 1'b1;
  endsequence
  // full-scale step held for at least eight cycles
  sequence fs_step_s;
    fs_internal_ref [*8];
  endsequence
  chk_bus_zero_wait: assert property (hreadyout && !hresp)
    else $error("bus wait state or error response");
  chk_write_data_ready_n_high: assert property (ctrl_wr_s |-> ##[0:2] data_ready_n)
    else $error("data ready not raised after control write");
  chk_fs_phase_hold: assert property ($rose(fs_internal_ref) |-> fs_step_s)
    else $error("full-scale step cut short");
  chk_fs_data_ready_n_high: assert property ($rose(fs_internal_ref) |-> data_ready_n throughout fs_step_s)
    else $error("data ready low during calibration");
  chk_ref_short_excl: assert property (!(fs_internal_ref && short_inputs))
    else $error("internal reference and shorted inputs together");
  chk_coef_one_pulse: assert property (zs_coef_update |=> !zs_coef_update)
    else $error("coefficient update longer than one cycle");
  chk_coef_after_short: assert property (zs_coef_update |->
    $past(short_inputs) || fs_internal_ref)
    else $error("coefficient update without a zero-scale phase");
  chk_word_after_cal: assert property ($fell(data_ready_n) |-> !fs_internal_ref)
    else $error("word flagged during full-scale step");
endmodule
bind acs_top acs_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .data_ready_n(data_ready_n), .short_inputs(short_inputs), .fs_internal_ref(fs_internal_ref),
  .zs_coef_update(zs_coef_update));

/* File: tb/acs_fe_model.sv */
// analog front-end model: fixed word, settling flag
// assumes the bench raises unsteady to disturb the input
`timescale 1ns/1ns
module acs_fe_model #(parameter logic [23:0] WORD = 24'h5a3c96) (
  input wire hclk,
  input wire hresetn,
  input wire unsteady,
  output logic [23:0] conv_word,
  output logic inputs_stable
);
  // input held still unless disturbed on command
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_word <= ~WORD;
      inputs_stable <= 1'b0;
    end else begin
      inputs_stable <= !unsteady;
      conv_word <= unsteady ? ~conv_word : WORD;
    end
  end
endmodule

/* File: tb/tb_top.sv */
// self-checking bench of the calibration sequencer
// assumes zero-wait slave and the front-end model
`timescale 1ns/1ns
module tb_top;
  // ****
  // stimulus and checks
  // ****
  localparam logic [23:0] WORD = 24'h5a3c96;
  localparam logic [2:0] MD [4] = '{3'h4, 3'h6, 3'h0, 3'h5};
  localparam logic [2:0] CH [4] = '{3'h1, 3'h7, 3'h0, 3'h3};
  localparam logic [2:0] EM [4] = '{3'h0, 3'h0, 3'h0, 3'h5};
  localparam logic [3:0] EF = 4'b0001;
  localparam logic [3:0] ES = 4'b0010;
  localparam logic [3:0] EI = 4'b0011;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic unsteady = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  wire [31:0] hrdata;
  wire [23:0] conv_word;
  wire hreadyout, hresp, inputs_stable, data_ready_n, short_inputs, fs_internal_ref;
  wire zs_coef_update, irq;
  int bad_count = 0;
  int checked = 0;
  int fs_n = 0;
  int sh_n = 0;
  int cf_n = 0;
  int f0, s0, k;
  always #50 hclk = ~hclk;
  // count phases seen on the front-end controls
  always @(posedge hclk) begin
    fs_n <= fs_n + int'(fs_internal_ref);
    sh_n <= sh_n + int'(short_inputs);
    cf_n <= cf_n + int'(zs_coef_update);
  end
  acs_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .conv_word(conv_word), .inputs_stable(inputs_stable),
    .data_ready_n(data_ready_n), .short_inputs(short_inputs), .fs_internal_ref(fs_internal_ref),
    .zs_coef_update(zs_coef_update), .irq(irq));
  acs_fe_model #(.WORD(WORD)) u_fe (.hclk(hclk), .hresetn(hresetn), .unsteady(unsteady),
    .conv_word(conv_word), .inputs_stable(inputs_stable));
  task automatic print_verdict;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // wait for a sampled ready, bounded
  task automatic rdy;
    int n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        chk("hready wait", 0, 1);
        print_verdict();
      end
      @(posedge hclk);
    end
  endtask
  // one single word transfer, read data into rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask
  // wait for a new word flagged, bounded
  task automatic wait_low(int lim);
    int n = 0;
    while (data_ready_n !== 1'b0) begin
      @(posedge hclk);
      n++;
      if (n > lim) begin
        chk("data_ready_n wait", 1, 0);
        print_verdict();
      end
    end
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b1, 8'h08, 32'h1);
    bus(1'b1, 8'h20, 32'hff);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", rd, 32'h0);
    // table rows: one mode each
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h00, {25'h0, MD[i], 1'b0, CH[i]});
      @(posedge hclk);
      chk("data_ready_n start", data_ready_n, 1);
      f0 = fs_n;
      s0 = sh_n;
      wait_low(700);
      chk("fs step", fs_n != f0, EF[i]);
      if (MD[i] != 3'h5)
        chk("short", sh_n != s0, ES[i]);
      bus(1'b0, 8'h10, 32'h0);
      chk("data", rd, {8'h0, WORD});
      bus(1'b0, 8'h00, 32'h0);
      chk("ctrl", rd, {25'h0, EM[i], 1'b0, CH[i]});
      chk("irq", irq, EI[i]);
      bus(1'b0, 8'h04, 32'h0);
      chk("stat done", rd[0], EI[i]);
      repeat (2) @(posedge hclk);
      chk("irq clear", irq, 0);
      $display("row %0d done", i);
    end
    // background keeps calibrating until rewritten
    f0 = cf_n;
    s0 = sh_n;
    for (k = 0; k < 1000 && cf_n == f0; k++)
      @(posedge hclk);
    chk("coef update", cf_n != f0, 1);
    chk("bk short", sh_n != s0, 1);
    bus(1'b0, 8'h04, 32'h0);
    chk("stat bk", rd[2], 1);
    bus(1'b0, 8'h00, 32'h0);
    chk("ctrl bk", rd[6:4], 3'h5);
    $display("background done");
    // offset calibration waits for a settled input
    unsteady <= 1'b1;
    repeat (4) @(posedge hclk);
    bus(1'b1, 8'h00, 32'h42);
    f0 = fs_n;
    repeat (300) @(posedge hclk);
    chk("fs held", fs_n, f0);
    chk("data_ready_n held", data_ready_n, 1);
    unsteady <= 1'b0;
    wait_low(700);
    chk("fs late", fs_n != f0, 1);
    bus(1'b0, 8'h00, 32'h0);
    chk("ctrl late", rd, 32'h2);
    bus(1'b0, 8'h14, 32'h0);
    chk("zs coef", rd, {5'h0, 3'h2, WORD});
    bus(1'b0, 8'h18, 32'h0);
    chk("fs coef", rd, {8'h0, WORD});
    $display("settle done");
    // reset in mid-calibration
    bus(1'b1, 8'h00, 32'h60);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b0;
    hsel <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("rst data_ready_n", data_ready_n, 1);
    chk("rst short", short_inputs, 0);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 8'h00, 32'h0);
    chk("rst ctrl", rd, 32'h0);
    bus(1'b0, 8'h08, 32'h0);
    chk("rst mask", rd, 32'h0);
    $display("reset done");
    print_verdict();
  end
endmodule
